// file: verilog/spi_sel_pkg.sv
package spi_sel_pkg;

	// ---------------------------------------------------------------
	// Frame sizes
	// ---------------------------------------------------------------
	localparam int CMD_BITS      = 22;
	localparam int OUT_BITS      = 22;
	localparam int READ_OPT_BITS = 20;
	localparam int CNT_W         = 6;

	// ---------------------------------------------------------------
	// Protocol encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] IN_MODE_00   = 2'h0;
	localparam logic [1:0] IN_MODE_01   = 2'h1;
	localparam logic [1:0] IN_MODE_10   = 2'h2;
	localparam logic [1:0] IN_MODE_11   = 2'h3;
	localparam logic [1:0] OUT_LEGACY   = 2'h0;
	localparam logic [1:0] OUT_EARLY    = 2'h1;
	localparam logic [1:0] OUT_SRC      = 2'h3;
	localparam logic [1:0] CLK_ECHO     = 2'h0;
	localparam logic [7:0] CTRL_DAISY_A = 8'h00;
	localparam logic [7:0] CTRL_DAISY_B = 8'h01;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [1:0]          IN_MODE_RST = 2'h0;
	localparam logic [7:0]          CTRL_RST    = 8'h00;
	localparam logic [CMD_BITS-1:0] IDR_RST     = 22'h000000;

	typedef struct packed {
		logic [1:0] input_protocol_select;
		logic [7:0] output_control_reg;
		logic [1:0] source_sync_clock_select;
	} cfg_t;

	typedef struct packed {
		logic                valid;
		logic [CMD_BITS-1:0] word;
	} cmd_t;

endpackage

// file: verilog/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// Pins in, synchronised levels out
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_r;
	logic [W-1:0] sync_nxt;

	always_comb begin
		meta_nxt = din;
		sync_nxt = meta_r;
	end

	// Idle-high reset keeps chip select inactive until the pins settle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= '1;
			sync_r <= '1;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign dout = sync_r;
endmodule

// file: verilog/adc_serial_protocol_select.sv
// Function
// - Reset selects idle-low rising-capture mode
// - Input select codes four clock polarity/phase modes
// - Command accepted only with 22+ clocks
// - Writes always follow the input mode
// - Optimal legacy read is 20 clocks
// - MSB at chip select or first clock
// - Early launch only for input modes 00/10
// - Early launch moves bits half clock earlier
// - Legacy launch and capture on opposite edges
// - Strobe held low during legacy frames
// - Long frame daisy-chains for control 00h/01h
// - Source-sync mode echoes clock on strobe
// - Zone-2 source-sync supports echo clock only
// - Short frame no-op, long keeps last 22
// - Bits shifted in short frames are discarded
// - Chip select rise releases lane, passes word
`timescale 1ns/1ps
module adc_serial_protocol_select (
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            sys_rst,
	// Link pins from the host
	input  wire logic                            cs_n,
	input  wire logic                            sclk,
	input  wire logic                            sdi,
	// Link pins to the host
	output logic                                 serial_out_lane0,
	output logic                                 serial_out_lane0_oe,
	output logic                                 ready_strobe_pin,
	// Configuration and conversion data
	input  wire spi_sel_pkg::cfg_t               cfg,
	input  wire logic [spi_sel_pkg::OUT_BITS-1:0] out_word,
	// Command word and status
	output spi_sel_pkg::cmd_t                    cmd,
	output logic                                 frame_short,
	output logic                                 read_optimal,
	output logic                                 cfg_unsupported
);
	localparam int CW = spi_sel_pkg::CNT_W;
	localparam int OB = spi_sel_pkg::OUT_BITS;
	localparam int IB = spi_sel_pkg::CMD_BITS;
	localparam logic [CW-1:0] CNT_CMD  = CW'(spi_sel_pkg::CMD_BITS);
	localparam logic [CW-1:0] CNT_READ = CW'(spi_sel_pkg::READ_OPT_BITS);
	localparam logic [CW-1:0] CNT_MAX  = '1;

	typedef enum logic {ST_IDLE, ST_FRAME} state_t;

	// ---------------------------------------------------------------
	// Pin synchronisers and edges
	// ---------------------------------------------------------------
	logic [2:0] pins_s;
	logic       cs_s;
	logic       sclk_s;
	logic       sdi_s;

	pin_sync #(.W(3)) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.din     ({cs_n, sclk, sdi}),
		.dout    (pins_s)
	);

	assign cs_s   = pins_s[2];
	assign sclk_s = pins_s[1];
	assign sdi_s  = pins_s[0];

	// ---------------------------------------------------------------
	// Frame state
	// ---------------------------------------------------------------
	state_t                st_r,      st_nxt;
	logic                  cs_prev_r, cs_prev_nxt;
	logic                  ck_prev_r, ck_prev_nxt;
	logic [1:0]            mode_r,    mode_nxt;
	logic [7:0]            ctrl_r,    ctrl_nxt;
	logic [1:0]            csel_r,    csel_nxt;
	logic [IB-1:0]         idr_r,     idr_nxt;
	logic [OB-1:0]         odr_r,     odr_nxt;
	logic [CW-1:0]         cnt_r,     cnt_nxt;
	logic                  first_r,   first_nxt;
	logic                  oe_r,      oe_nxt;
	logic                  strb_r,    strb_nxt;
	spi_sel_pkg::cmd_t     cmd_r,     cmd_nxt;
	logic                  short_r,   short_nxt;
	logic                  ropt_r,    ropt_nxt;

	logic cs_fall, cs_rise, ck_rise, ck_fall;
	logic in_frame, cap_rise, capture, launch;
	logic early_launch, src, daisy, late_msb, shift_en;

	// Rising capture for modes 00 and 11, falling for 01 and 10
	function automatic logic capture_on_rise(input logic [1:0] m);
		capture_on_rise = (m == spi_sel_pkg::IN_MODE_00) ||
			(m == spi_sel_pkg::IN_MODE_11);
	endfunction

	always_comb begin
		cs_fall  = cs_prev_r & ~cs_s;
		cs_rise  = ~cs_prev_r & cs_s;
		ck_rise  = ~ck_prev_r & sclk_s;
		ck_fall  = ck_prev_r & ~sclk_s;
		in_frame = (st_r == ST_FRAME) & ~cs_rise;
		cap_rise = capture_on_rise(mode_r);
		capture  = in_frame & (cap_rise ? ck_rise : ck_fall);
		launch   = in_frame & (cap_rise ? ck_fall : ck_rise);
		early_launch      = (ctrl_r[1:0] == spi_sel_pkg::OUT_EARLY) &
			~mode_r[0];
		src      = ctrl_r[1:0] == spi_sel_pkg::OUT_SRC;
		daisy    = (ctrl_r == spi_sel_pkg::CTRL_DAISY_A) ||
			(ctrl_r == spi_sel_pkg::CTRL_DAISY_B);
		late_msb = mode_r[0];
		// Early launch moves the shift onto the capture edge
		if (src)
			shift_en = in_frame & ck_rise & ~first_r;
		else if (early_launch)
			shift_en = capture;
		else
			shift_en = launch & ~(late_msb & first_r);
	end

	always_comb begin
		st_nxt      = st_r;
		cs_prev_nxt = cs_s;
		ck_prev_nxt = sclk_s;
		mode_nxt    = mode_r;
		ctrl_nxt    = ctrl_r;
		csel_nxt    = csel_r;
		idr_nxt     = idr_r;
		odr_nxt     = odr_r;
		cnt_nxt     = cnt_r;
		first_nxt   = first_r;
		oe_nxt      = oe_r;
		strb_nxt    = strb_r;
		cmd_nxt     = '0;
		short_nxt   = short_r;
		ropt_nxt    = ropt_r;
		unique case (st_r)
			ST_IDLE: begin
				strb_nxt = 1'b1;
				oe_nxt   = 1'b0;
				if (cs_fall) begin
					st_nxt    = ST_FRAME;
					// Modes are frozen for the whole frame
					mode_nxt  = cfg.input_protocol_select;
					ctrl_nxt  = cfg.output_control_reg;
					csel_nxt  = cfg.source_sync_clock_select;
					idr_nxt   = spi_sel_pkg::IDR_RST;
					odr_nxt   = out_word;
					cnt_nxt   = '0;
					first_nxt = 1'b1;
					oe_nxt    = 1'b1;
					strb_nxt  = 1'b0;
				end
			end
			ST_FRAME: begin
				if (capture) begin
					idr_nxt = {idr_r[IB-2:0], sdi_s};
					if (cnt_r != CNT_MAX)
						cnt_nxt = cnt_r + 1'b1;
				end
				if (shift_en) begin
					// Daisy chain passes host data through behind the word
					odr_nxt = {odr_r[OB-2:0], daisy & sdi_s};
				end
				if (launch || (src && ck_rise))
					first_nxt = 1'b0;
				// Echo is the only clock source this block can give
				if (src && csel_r == spi_sel_pkg::CLK_ECHO)
					strb_nxt = sclk_s;
				else
					strb_nxt = 1'b0;
				if (cs_rise) begin
					st_nxt      = ST_IDLE;
					oe_nxt      = 1'b0;
					strb_nxt    = 1'b1;
					cmd_nxt.valid = cnt_r >= CNT_CMD;
					cmd_nxt.word  = idr_r;
					short_nxt   = cnt_r < CNT_CMD;
					ropt_nxt    = cnt_r >= CNT_READ;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r      <= ST_IDLE;
			cs_prev_r <= 1'b1;
			ck_prev_r <= 1'b0;
			mode_r    <= spi_sel_pkg::IN_MODE_RST;
			ctrl_r    <= spi_sel_pkg::CTRL_RST;
			csel_r    <= spi_sel_pkg::CLK_ECHO;
			idr_r     <= spi_sel_pkg::IDR_RST;
			odr_r     <= '0;
			cnt_r     <= '0;
			first_r   <= 1'b0;
			oe_r      <= 1'b0;
			strb_r    <= 1'b1;
			cmd_r     <= '0;
			short_r   <= 1'b0;
			ropt_r    <= 1'b0;
		end else begin
			st_r      <= st_nxt;
			cs_prev_r <= cs_prev_nxt;
			ck_prev_r <= ck_prev_nxt;
			mode_r    <= mode_nxt;
			ctrl_r    <= ctrl_nxt;
			csel_r    <= csel_nxt;
			idr_r     <= idr_nxt;
			odr_r     <= odr_nxt;
			cnt_r     <= cnt_nxt;
			first_r   <= first_nxt;
			oe_r      <= oe_nxt;
			strb_r    <= strb_nxt;
			cmd_r     <= cmd_nxt;
			short_r   <= short_nxt;
			ropt_r    <= ropt_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign serial_out_lane0    = odr_r[OB-1];
	assign serial_out_lane0_oe = oe_r;
	assign ready_strobe_pin    = strb_r;
	assign cmd                 = cmd_r;
	assign frame_short         = short_r;
	assign read_optimal        = ropt_r;
	assign cfg_unsupported     = src &&
		csel_r != spi_sel_pkg::CLK_ECHO;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_frame_end;
		st_r == ST_FRAME && cs_rise;
	endsequence

	sequence s_frame_start;
		st_r == ST_IDLE && cs_fall;
	endsequence

	AST_SHORT_NOP: assert property (
		s_frame_end and cnt_r < CNT_CMD |=> !cmd.valid)
		else $error("short frame produced a command");
	AST_CMD_OK: assert property (
		s_frame_end and cnt_r >= CNT_CMD |=>
		cmd.valid && cmd.word == $past(idr_r))
		else $error("full frame lost its command");
	AST_RELEASE: assert property (
		s_frame_end |=> !serial_out_lane0_oe ##1 !serial_out_lane0_oe)
		else $error("lane not released after frame");
	AST_LOAD: assert property (
		s_frame_start |=> serial_out_lane0_oe &&
		serial_out_lane0 == $past(out_word[OB-1]))
		else $error("msb not presented at frame start");
	AST_CNT_CLR: assert property (
		s_frame_start |=> cnt_r == '0)
		else $error("edge count not cleared");
	AST_CNT_INC: assert property (
		capture && cnt_r < CNT_MAX |=> cnt_r == $past(cnt_r) + 1'b1)
		else $error("capture edge not counted");
	AST_STROBE_LOW: assert property (
		st_r == ST_FRAME && !src ##1 st_r == ST_FRAME |->
		!ready_strobe_pin)
		else $error("strobe high during legacy frame");
	AST_EDL_GATE: assert property (
		st_r == ST_FRAME && mode_r[0] && !src |->
		shift_en == (launch && !first_r))
		else $error("early launch active in late-phase mode");
	AST_MSB_FIRST: assert property (
		shift_en |=> odr_r[OB-1] == $past(odr_r[OB-2]))
		else $error("output not shifted msb first");
	AST_NO_DAISY: assert property (
		shift_en && !daisy |=> odr_r[0] == 1'b0)
		else $error("zero fill missing without daisy chain");
endmodule

// file: sim/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
	// Clock
	input  wire logic        clk,
	// Pins toward the device
	output logic             cs_n,
	output logic             sclk,
	output logic             sdi,
	// Pins from the device
	input  wire logic        lane,
	input  wire logic        lane_oe,
	input  wire logic        strobe,
	// Frame result
	output logic [63:0]      rx,
	output logic             done,
	output int               n_strobe
);
	logic lane_w;
	logic last_r = 1'b0;

	// Released lane shows the inverse of its last level, never a held bit
	assign lane_w = lane_oe ? lane : ~last_r;
	always @(posedge clk) if (lane_oe) last_r <= lane;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
		rx = '0;
		done = 1'b0;
		n_strobe = 0;
	end

	task automatic half();
		repeat (4) begin
			@(negedge clk);
			n_strobe += int'(strobe);
		end
	endtask

	task automatic grab();
		rx = {rx[62:0], lane_w};
	endtask

	// smp: 0 before trailing edge, 1 before next leading, 2 before leading
	task automatic frame(input logic [1:0] mode, input logic [1:0] smp,
			input int ncyc, input logic [63:0] tx);
		rx = '0;
		sclk = mode[1];
		@(negedge clk);
		cs_n = 1'b0;
		sdi = tx[ncyc-1];
		half();
		half();
		n_strobe = 0;
		for (int k = ncyc - 1; k >= 0; k--) begin
			if (smp == 2'h2) grab();
			if (mode[0]) sdi = tx[k];
			sclk = ~sclk;
			half();
			if (smp == 2'h0) grab();
			sclk = ~sclk;
			if (!mode[0] && k > 0) sdi = tx[k-1];
			half();
			if (smp == 2'h1) grab();
		end
		cs_n = 1'b1;
		repeat (6) @(negedge clk);
		done = 1'b1;
		@(negedge clk);
		done = 1'b0;
	endtask
endmodule

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
	logic                             clk;
	logic                             sys_rst;
	logic                             cs_n;
	logic                             sclk;
	logic                             sdi;
	logic                             serial_out_lane0;
	logic                             serial_out_lane0_oe;
	logic                             ready_strobe_pin;
	logic                             done;
	logic                             frame_short;
	logic                             read_optimal;
	logic                             cfg_unsupported;
	spi_sel_pkg::cfg_t                cfg;
	spi_sel_pkg::cmd_t                cmd;
	logic [spi_sel_pkg::OUT_BITS-1:0] out_word;
	logic [63:0]                      rx;
	int                               n_strobe;
	int                               n_errors = 0;
	int                               n_tests = 0;
	int                               seed = 32'h8C64;
	logic [21:0]                      q_cmd[$];
	logic [63:0]                      q_rx[$];
	// Fields: mode[19:18] ctrl[17:10] csel[9:8] smp[7:6] clocks[5:0]
	localparam logic [19:0] TBL [13] = '{20'h00016, 20'h40056,
		20'h80016, 20'hC0056, 20'h00014, 20'hC0053, 20'h0001E,
		20'h8201E, 20'h00496, 20'h80496, 20'h40456, 20'h00C56,
		20'h00D56};

	adc_serial_protocol_select i_dut (.clk(clk), .sys_rst(sys_rst),
		.cs_n(cs_n), .sclk(sclk), .sdi(sdi),
		.serial_out_lane0(serial_out_lane0),
		.serial_out_lane0_oe(serial_out_lane0_oe),
		.ready_strobe_pin(ready_strobe_pin), .cfg(cfg),
		.out_word(out_word), .cmd(cmd), .frame_short(frame_short),
		.read_optimal(read_optimal), .cfg_unsupported(cfg_unsupported));

	spi_host_model i_host (.clk(clk), .cs_n(cs_n), .sclk(sclk),
		.sdi(sdi), .lane(serial_out_lane0),
		.lane_oe(serial_out_lane0_oe), .strobe(ready_strobe_pin),
		.rx(rx), .done(done), .n_strobe(n_strobe));

	task automatic chk_cmd(input logic [21:0] got, input logic [21:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bits(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("tests=%0d errors=%0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Watchdog sized well above thirteen frames of at most 30 clocks
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		end_of_test();
	end

	// -----------------------------------------------------------------
	// Result monitor
	// -----------------------------------------------------------------
	// Registered pulse is read mid-cycle, clear of the edge that launches it
	always @(negedge clk) begin
		if (cmd.valid === 1'b1) begin
			if (q_cmd.size() != 0)
				chk_cmd(cmd.word, q_cmd.pop_front());
			else
				chk_bits(64'h1, 64'h0);
		end
	end

	always @(posedge clk) begin
		if (done === 1'b1)
			chk_bits(rx, q_rx.pop_front());
	end

	initial begin
		logic [19:0] e;
		logic [63:0] tx;
		logic [63:0] ex;
		int n;
		logic uns;
		cfg = '0;
		out_word = '0;
		sys_rst = 1'b1;
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 13; i++) begin
			e = TBL[i];
			n = int'(e[5:0]);
			out_word = 22'($random(seed));
			tx = {32'($random(seed)), 32'($random(seed))};
			// Ones ahead of the command keep daisy bits timing-proof
			if (n > 22) tx[63:21] = '1;
			ex = '0;
			for (int k = 0; k < n; k++)
				ex = {ex[62:0], (k < 22) ? out_word[21-k] : e[17:11] == 7'h0};
			cfg = spi_sel_pkg::cfg_t'(e[19:8]);
			q_rx.push_back(ex);
			if (n >= 22) q_cmd.push_back(tx[21:0]);
			i_host.frame(e[19:18], e[7:6], n, tx);
			chk_bits(64'(frame_short), 64'(n < 22));
			chk_bits(64'(read_optimal), 64'(n >= 20));
			chk_bits(64'(serial_out_lane0_oe), 64'h0);
			uns = (e[11:10] == 2'h3) && (e[9:8] != 2'h0);
			chk_bits(64'(cfg_unsupported), 64'(uns));
			chk_bits(64'(n_strobe != 0), 64'(e[11:8] == 4'hC));
		end
		chk_bits(64'(q_cmd.size()), 64'h0);
		chk_bits(64'(q_rx.size()), 64'h0);
		end_of_test();
	end
endmodule
